// ---- hdl/sec_ctrl.sv ----
/*
  Serial EEPROM access controller: AXI4-Lite register slave, command
  sequencer for a 16-bit-word SPI EEPROM, autoload after fundamental reset,
  and a sticky interrupt status with mask.
  Assumes synchronous inputs on mclk and an SPI mode 0 EEPROM on the pins.
*/
// Summary of operation
// - Writing start one in the idle state, with no autoload pending, launches one transaction with the held command.
// - Command codes 1..6 select status write, write, read, disable, status read, enable.
// - Autoload status reads one only after successful autoload; resets to zero.
// - Autoload disable bit suppresses autoload; resets to one.
// - Rate code 01b gives serial clock of core clock divided by 64.
// - Rate code 11b selects test mode; codes 00b and 10b reserved.
// - Write-in-process bit shows EEPROM busy with a write; resets zero.
// - Bit nine mirrors the EEPROM write-enable latch; resets zero.
// - Block protect bits and write protect enable mirror EEPROM status.
// - Address field bits 15:0 supply EEPROM location; resets zero.
// - Data field bits 31:16 hold write value or read result.
`timescale 1ns/1ps
module sec_ctrl
  import sec_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic                  fundamental_reset_input_n,
  input  wire sec_pkg::sec_axi_req_t axi_req,
  output sec_pkg::sec_axi_rsp_t      axi_rsp,
  output sec_pkg::sec_spi_t          spi_out,
  input  wire logic                  spi_miso,
  output logic                       irq
);
  import sec_pkg::*;

  // Opcode lookup for a command code
  function automatic logic [7:0] sec_opcode(input logic [2:0] c);
    case (c)
      SEC_CMD_WRSR:  sec_opcode = SEC_OP_WRSR;
      SEC_CMD_WRITE: sec_opcode = SEC_OP_WRITE;
      SEC_CMD_READ:  sec_opcode = SEC_OP_READ;
      SEC_CMD_WRDI:  sec_opcode = SEC_OP_WRDI;
      SEC_CMD_RDSR:  sec_opcode = SEC_OP_RDSR;
      default:       sec_opcode = SEC_OP_WREN;
    endcase
  endfunction : sec_opcode

  // Number of serial bits a command moves
  function automatic logic [5:0] sec_bits(input logic [2:0] c);
    case (c)
      SEC_CMD_WRITE, SEC_CMD_READ: sec_bits = 6'd40;
      SEC_CMD_WRSR, SEC_CMD_RDSR:  sec_bits = 6'd16;
      default:                     sec_bits = 6'd8;
    endcase
  endfunction : sec_bits

  logic             start_q;
  logic [2:0]       cmd_q;
  logic             al_ok_q;
  logic             al_dis_q;
  logic [1:0]       rate_q;
  logic [7:0]       sr_q;
  logic [15:0]      addr_q;
  logic [15:0]      data_q;
  logic [15:0]      cfg_q;
  logic [2:0]       ist_q;
  logic [2:0]       imsk_q;
  sec_state_t       st_q;
  logic [39:0]      sh_q;
  logic [5:0]       bits_q;
  logic [7:0]       div_q;
  logic             sck_q;
  logic             cs_n_q;
  logic [1:0]       al_idx_q;
  logic             prst_q;
  logic             al_req_q;
  logic             aw_q;
  logic             w_q;
  logic [7:0]       awa_q;
  logic [31:0]      wd_q;
  logic [3:0]       ws_q;
  logic             bv_q;
  logic [1:0]       br_q;
  logic             rv_q;
  logic [31:0]      rd_q;
  logic [1:0]       rr_q;
  logic             done_ev;
  logic             al_ev;
  logic             wr_fire;
  logic             rd_fire;
  logic [7:0]       half_lim;
  logic [31:0]      ctrl_word;

  assign half_lim = (rate_q == SEC_RATE_TEST) ? 8'(SEC_TEST_HALF) : 8'(SEC_HALF_CYC);
  assign wr_fire  = aw_q && w_q && !bv_q;
  assign rd_fire  = axi_req.arvalid && !rv_q;
  assign ctrl_word = {16'h0000, sr_q[7], 3'h0, sr_q[3:0], rate_q, al_dis_q, al_ok_q,
                      cmd_q, start_q};

  // Write address and data capture, in either order
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      aw_q  <= 1'b0;
      w_q   <= 1'b0;
      awa_q <= 8'h00;
      wd_q  <= 32'h0000_0000;
      ws_q  <= 4'h0;
    end else begin
      if (axi_req.awvalid && !aw_q) begin
        aw_q  <= 1'b1;
        awa_q <= axi_req.awaddr;
      end
      if (axi_req.wvalid && !w_q) begin
        w_q  <= 1'b1;
        wd_q <= axi_req.wdata;
        ws_q <= axi_req.wstrb;
      end
      // Both stay held until the answer is taken, so no write slips in under bvalid
      if (bv_q && axi_req.bready) begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
      end
    end
  end

  // Write response and read data channels
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bv_q <= 1'b0;
      br_q <= 2'h0;
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= 2'h0;
    end else begin
      if (wr_fire) begin
        bv_q <= 1'b1;
        br_q <= (awa_q == SEC_OFS_CTRL || awa_q == SEC_OFS_ADDAT || awa_q == SEC_OFS_IMASK
                 || awa_q == SEC_OFS_ISTAT || awa_q == SEC_OFS_CFG) ? 2'h0 : 2'h2;
      end else if (bv_q && axi_req.bready) begin
        bv_q <= 1'b0;
      end
      if (rd_fire) begin
        rv_q <= 1'b1;
        rr_q <= 2'h0;
        case (axi_req.araddr)
          SEC_OFS_CTRL:  rd_q <= ctrl_word;
          SEC_OFS_ADDAT: rd_q <= {data_q, addr_q};
          SEC_OFS_ISTAT: rd_q <= {29'h0, ist_q};
          SEC_OFS_IMASK: rd_q <= {29'h0, imsk_q};
          SEC_OFS_CFG:   rd_q <= {16'h0000, cfg_q};
          default: begin
            rd_q <= 32'h0000_0000;
            rr_q <= 2'h2;
          end
        endcase
      end else if (rv_q && axi_req.rready) begin
        rv_q <= 1'b0;
      end
    end
  end

  // Software-owned control fields
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmd_q    <= SEC_RST_CMD;
      al_dis_q <= SEC_RST_ALDIS;
      rate_q   <= SEC_RST_RATE;
      addr_q   <= SEC_RST_WORD;
      imsk_q   <= 3'h0;
    end else if (wr_fire) begin
      if (awa_q == SEC_OFS_CTRL && ws_q[0]) begin
        cmd_q    <= wd_q[SEC_B_CMD +: 3];
        al_dis_q <= wd_q[SEC_B_ALDIS];
        rate_q   <= wd_q[SEC_B_RATE +: 2];
      end
      if (awa_q == SEC_OFS_ADDAT && ws_q[0]) addr_q[7:0] <= wd_q[7:0];
      if (awa_q == SEC_OFS_ADDAT && ws_q[1]) addr_q[15:8] <= wd_q[15:8];
      if (awa_q == SEC_OFS_IMASK && ws_q[0]) imsk_q <= wd_q[2:0];
    end
  end

  // Previous fundamental reset level, to see its release
  always_ff @(posedge mclk) begin
    if (!rstn) prst_q <= 1'b0;
    else       prst_q <= fundamental_reset_input_n;
  end

  // Autoload request on release of the fundamental reset
  always_ff @(posedge mclk) begin
    if (!rstn || !fundamental_reset_input_n) begin
      al_req_q <= 1'b0;
    end else if (fundamental_reset_input_n && !prst_q && !al_dis_q) begin
      al_req_q <= 1'b1;
    end else if (st_q == SEC_AUTO) begin
      al_req_q <= 1'b0;
    end
  end

  // Transaction sequencer and serial shifter
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q     <= SEC_IDLE;
      start_q  <= 1'b0;
      sh_q     <= 40'h0;
      bits_q   <= 6'h0;
      div_q    <= 8'h00;
      sck_q    <= 1'b0;
      cs_n_q   <= 1'b1;
      data_q   <= SEC_RST_WORD;
      sr_q     <= 8'h00;
      cfg_q    <= SEC_RST_CFG;
      al_ok_q  <= 1'b0;
      al_idx_q <= 2'h0;
    end else begin
      if (!fundamental_reset_input_n) al_ok_q <= 1'b0;
      if (wr_fire && awa_q == SEC_OFS_ADDAT) begin
        if (ws_q[2]) data_q[7:0]  <= wd_q[23:16];
        if (ws_q[3]) data_q[15:8] <= wd_q[31:24];
      end
      if (wr_fire && awa_q == SEC_OFS_CTRL && ws_q[1]) begin
        sr_q[2] <= wd_q[SEC_B_BP0];
        sr_q[3] <= wd_q[SEC_B_BP1];
        sr_q[7] <= wd_q[SEC_B_WPEN];
      end
      if (wr_fire && awa_q == SEC_OFS_CTRL && ws_q[0] && wd_q[SEC_B_START]
          && st_q == SEC_IDLE) begin
        start_q <= 1'b1;
      end
      case (st_q)
        SEC_IDLE: begin
          if (al_req_q) begin
            al_idx_q <= 2'h0;
            sh_q     <= {SEC_OP_READ, 16'h0000, 16'h0000};
            bits_q   <= 6'd40;
            st_q     <= SEC_AUTO;
            cs_n_q   <= 1'b0;
          end else if (start_q) begin
            st_q <= SEC_LOAD;
          end
        end
        SEC_LOAD: begin
          sh_q   <= {sec_opcode(cmd_q), (cmd_q == SEC_CMD_WRSR) ? sr_q : addr_q[15:8],
                     (cmd_q == SEC_CMD_WRSR) ? 8'h00 : addr_q[7:0], data_q};
          bits_q <= sec_bits(cmd_q);
          div_q  <= 8'h00;
          cs_n_q <= 1'b0;
          st_q   <= SEC_SHIFT;
        end
        SEC_SHIFT, SEC_AUTO: begin
          if (div_q == half_lim - 8'h01 && cs_n_q) begin
            div_q  <= 8'h00;
            cs_n_q <= 1'b0; // Reselect after the gap between autoload frames
          end else if (div_q == half_lim - 8'h01) begin
            div_q <= 8'h00;
            sck_q <= !sck_q;
            if (sck_q) begin
              sh_q   <= {sh_q[38:0], spi_miso};
              bits_q <= bits_q - 6'd1;
              if (bits_q == 6'd1) begin
                sck_q  <= 1'b0;
                cs_n_q <= 1'b1;
                if (st_q == SEC_AUTO) begin
                  cfg_q[al_idx_q*4 +: 4] <= {sh_q[2:0], spi_miso};
                  al_idx_q <= al_idx_q + 2'h1;
                  if (al_idx_q == 2'(SEC_AL_WORDS - 1)) begin
                    al_ok_q <= 1'b1;
                    st_q    <= SEC_DONE;
                  end else begin
                    // Chip select stays high for a half period so the memory sees a new command
                    sh_q   <= {SEC_OP_READ, 14'h0, al_idx_q + 2'h1, 16'h0000};
                    bits_q <= 6'd40;
                  end
                end else begin
                  st_q <= SEC_DONE;
                end
              end
            end
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
        SEC_DONE: begin
          if (start_q) begin
            if (cmd_q == SEC_CMD_READ) data_q <= sh_q[15:0];
            if (cmd_q == SEC_CMD_RDSR) sr_q <= sh_q[7:0];
            if (cmd_q == SEC_CMD_WREN) sr_q[1] <= 1'b1;
            if (cmd_q == SEC_CMD_WRDI) sr_q[1] <= 1'b0;
          end
          start_q <= 1'b0;
          st_q    <= SEC_IDLE;
        end
        default: st_q <= SEC_IDLE;
      endcase
    end
  end

  assign done_ev = (st_q == SEC_DONE) && start_q;
  assign al_ev   = (st_q == SEC_DONE) && !start_q;

  // Sticky interrupt status; an event in the read cycle wins over the clear
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ist_q <= 3'h0;
    end else begin
      if (rd_fire && axi_req.araddr == SEC_OFS_ISTAT) ist_q <= 3'h0;
      if (done_ev) ist_q[SEC_IRQ_DONE] <= 1'b1;
      if (al_ev)   ist_q[SEC_IRQ_AL]   <= 1'b1;
    end
  end

  // Registered interrupt and pin outputs
  always_ff @(posedge mclk) begin
    if (!rstn) irq <= 1'b0;
    else       irq <= |(ist_q & imsk_q);
  end

  assign spi_out.sck  = sck_q;
  assign spi_out.cs_n = cs_n_q;
  assign spi_out.mosi = sh_q[39];

  assign axi_rsp.awready = !aw_q;
  assign axi_rsp.wready  = !w_q;
  assign axi_rsp.bvalid  = bv_q;
  assign axi_rsp.bresp   = br_q;
  assign axi_rsp.arready = !rv_q;
  assign axi_rsp.rvalid  = rv_q;
  assign axi_rsp.rdata   = rd_q;
  assign axi_rsp.rresp   = rr_q;
endmodule : sec_ctrl

// ---- hdl/sec_pkg.sv ----
/*
  Package for the serial EEPROM access controller: register map, field
  positions, reset values, command codes, timing and bus carrier types.
  Assumes a 200 MHz mclk and a 32-bit AXI4-Lite register bus.
*/
package sec_pkg;
  // Register byte offsets
  localparam logic [7:0] SEC_OFS_CTRL   = 8'hA0;
  localparam logic [7:0] SEC_OFS_ADDAT  = 8'hA4;
  localparam logic [7:0] SEC_OFS_ISTAT  = 8'hB0;
  localparam logic [7:0] SEC_OFS_IMASK  = 8'hB4;
  localparam logic [7:0] SEC_OFS_CFG    = 8'hB8;
  // Control field positions
  localparam int SEC_B_START  = 0;
  localparam int SEC_B_CMD    = 1;
  localparam int SEC_B_ALST   = 4;
  localparam int SEC_B_ALDIS  = 5;
  localparam int SEC_B_RATE   = 6;
  localparam int SEC_B_WIP    = 8;
  localparam int SEC_B_WEL    = 9;
  localparam int SEC_B_BP0    = 10;
  localparam int SEC_B_BP1    = 11;
  localparam int SEC_B_WPEN   = 15;
  // Reset values
  localparam logic [2:0]  SEC_RST_CMD   = 3'h0;
  localparam logic [1:0]  SEC_RST_RATE  = 2'h1;
  localparam logic        SEC_RST_ALDIS = 1'b1;
  localparam logic [15:0] SEC_RST_WORD  = 16'h0000;
  localparam logic [15:0] SEC_RST_CFG   = 16'h0000;
  // Clock rate codes
  localparam logic [1:0] SEC_RATE_DIV64 = 2'h1;
  localparam logic [1:0] SEC_RATE_TEST  = 2'h3;
  // Commands
  localparam logic [2:0] SEC_CMD_WRSR  = 3'h1;
  localparam logic [2:0] SEC_CMD_WRITE = 3'h2;
  localparam logic [2:0] SEC_CMD_READ  = 3'h3;
  localparam logic [2:0] SEC_CMD_WRDI  = 3'h4;
  localparam logic [2:0] SEC_CMD_RDSR  = 3'h5;
  localparam logic [2:0] SEC_CMD_WREN  = 3'h6;
  // Serial opcodes sent on the wire
  localparam logic [7:0] SEC_OP_WRSR  = 8'h01;
  localparam logic [7:0] SEC_OP_WRITE = 8'h02;
  localparam logic [7:0] SEC_OP_READ  = 8'h03;
  localparam logic [7:0] SEC_OP_WRDI  = 8'h04;
  localparam logic [7:0] SEC_OP_RDSR  = 8'h05;
  localparam logic [7:0] SEC_OP_WREN  = 8'h06;
  // Serial clock timing: core clock / 64 at 250 MHz gives a 256 ns period
  localparam int SEC_CORE_MHZ   = 250;
  localparam int SEC_CORE_DIV   = 64;
  localparam int SEC_MCLK_MHZ   = 200;
  localparam int SEC_SCK_NS     = SEC_CORE_DIV * 1000 / SEC_CORE_MHZ;
  localparam int SEC_HALF_CYC   = (SEC_SCK_NS * SEC_MCLK_MHZ / 1000) / 2;
  localparam int SEC_TEST_HALF  = 1;
  localparam int SEC_AL_WORDS   = 4;
  // Interrupt status bits
  localparam int SEC_IRQ_DONE   = 0;
  localparam int SEC_IRQ_AL     = 1;
  localparam int SEC_IRQ_RSVD   = 2;
  // Transaction states, Gray-coded along the usual path
  typedef enum logic [2:0] {
    SEC_IDLE  = 3'b000,
    SEC_LOAD  = 3'b001,
    SEC_SHIFT = 3'b011,
    SEC_DONE  = 3'b010,
    SEC_AUTO  = 3'b110
  } sec_state_t;
  // AXI4-Lite carriers
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } sec_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sec_axi_rsp_t;
  // Serial EEPROM pins
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } sec_spi_t;
endpackage : sec_pkg

// ---- tb/sec_ctrl_monitor.sv ----
/* Checker for sec_ctrl: bus answers, serial clock timing.
   Bound to every sec_ctrl; sees its ports only. */
`timescale 1ns/1ps
module sec_ctrl_monitor
  import sec_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  rstn,
  input wire logic                  fundamental_reset_input_n,
  input wire sec_pkg::sec_axi_req_t axi_req,
  input wire sec_pkg::sec_axi_rsp_t axi_rsp,
  input wire sec_pkg::sec_spi_t     spi_out,
  input wire logic                  spi_miso,
  input wire logic                  irq
);
  logic [7:0] ra_q;
  logic [7:0] wa_q;
  logic [5:0] hc_q;
  function automatic logic mapped(input logic [7:0] a);
    return a inside {SEC_OFS_CTRL, SEC_OFS_ADDAT, SEC_OFS_ISTAT, SEC_OFS_IMASK, SEC_OFS_CFG};
  endfunction : mapped
  // Addresses of the transfers under way
  always_ff @(posedge mclk) begin
    if (axi_req.arvalid && axi_rsp.arready) ra_q <= axi_req.araddr;
    if (axi_req.awvalid && axi_rsp.awready) wa_q <= axi_req.awaddr;
  end
  // Cycles since the serial clock last moved
  always_ff @(posedge mclk) begin
    hc_q <= (!rstn || $changed(spi_out.sck)) ? 6'h00 : hc_q + 6'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_b_ans;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
      |-> ##[1:2] axi_rsp.bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("write answer late");
  property p_b_block; axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready; endproperty
  a_b_block: assert property (p_b_block) else $error("write taken during answer");
  property p_r_ans; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_ar_block; axi_rsp.rvalid |-> !axi_rsp.arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
  property p_rresp; axi_rsp.rvalid |-> axi_rsp.rresp == (mapped(ra_q) ? 2'h0 : 2'h2); endproperty
  a_rresp: assert property (p_rresp) else $error("wrong read response");
  property p_berr; axi_rsp.bvalid && !mapped(wa_q) |-> axi_rsp.bresp == 2'h2; endproperty
  a_berr: assert property (p_berr) else $error("unmapped write not refused");
  property p_sck_half;
    $fell(spi_out.sck) |-> hc_q == SEC_HALF_CYC - 1 || hc_q == SEC_TEST_HALF - 1;
  endproperty
  a_sck_half: assert property (p_sck_half) else $error("serial clock period");
  property p_sck_idle; spi_out.cs_n && $past(spi_out.cs_n) |-> !spi_out.sck; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock outside frame");
  property p_mosi; spi_out.sck |-> $stable(spi_out.mosi); endproperty
  a_mosi: assert property (p_mosi) else $error("data moved on high clock");
endmodule : sec_ctrl_monitor

bind sec_ctrl sec_ctrl_monitor u_mon (.mclk(mclk), .rstn(rstn),
  .fundamental_reset_input_n(fundamental_reset_input_n), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .spi_out(spi_out), .spi_miso(spi_miso), .irq(irq));

// ---- tb/sec_eeprom_model.sv ----
/* Behavioural serial EEPROM, mode 0, msb first, 16-bit words.
   Assumes framed traffic from the controller. */
`timescale 1ns/1ps
module sec_eeprom_model
  import sec_pkg::*;
(
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic mosi,
  output logic      miso
);
  logic [39:0] sh;
  logic [15:0] mem [16];
  logic [15:0] rd;
  logic [7:0]  sr;
  logic [7:0]  op;
  int          n;
  // Low nibble of each word is its own location, so autoload order shows
  initial begin
    miso = 1'b0;
    sr = 8'h00;
    op = 8'h00;
    n = 0;
    for (int i = 0; i < 16; i++) mem[i] = 16'hA5A0 | 16'(i);
  end
  always @(negedge cs_n) n = 0;
  // Busy flag clears once reported; released line toggles
  always @(posedge cs_n) begin
    miso = ~miso;
    if (op == SEC_OP_RDSR) sr[0] = 1'b0;
  end
  // Capture on the rising edge
  always @(posedge sck) begin
    if (!cs_n) begin
      sh = {sh[38:0], mosi};
      n = n + 1;
      if (n == 8) op = sh[7:0];
      if (n == 24) rd = mem[sh[3:0]];
      if (n == 16 && op == SEC_OP_WRSR) sr[7:2] = sh[7:2];
      if (n == 40 && op == SEC_OP_WRITE) begin
        mem[sh[19:16]] = sh[15:0];
        sr[0] = 1'b1;
      end
    end
  end
  // Shift out on the falling edge
  always @(negedge sck) begin
    if (!cs_n && op == SEC_OP_READ && n >= 24 && n < 40) miso = rd[39 - n];
    else if (!cs_n && op == SEC_OP_RDSR && n >= 8 && n < 16) miso = sr[15 - n];
    else miso = ~miso;
  end
endmodule : sec_eeprom_model

// ---- tb/tb_sec_ctrl.sv ----
/* Testbench for sec_ctrl: AXI4-Lite master tasks, EEPROM model on pins.
   Assumes the 200 MHz mclk and the hand-over bus timing. */
`timescale 1ns/1ps
module tb_sec_ctrl;
  import sec_pkg::*;
  logic         mclk;
  logic         rstn;
  logic         fr_n;
  sec_axi_req_t req;
  sec_axi_rsp_t rsp;
  sec_spi_t     spi;
  logic         miso;
  logic         irq;
  logic [31:0]  v;
  logic [1:0]   rs;
  int           num_errors;
  int           n_tests;
  sec_ctrl uut (.mclk(mclk), .rstn(rstn), .fundamental_reset_input_n(fr_n), .axi_req(req),
    .axi_rsp(rsp), .spi_out(spi), .spi_miso(miso), .irq(irq));
  sec_eeprom_model u_rom (.sck(spi.sck), .cs_n(spi.cs_n), .mosi(spi.mosi), .miso(miso));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Write: address and data offered together, bready held
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    rs = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
  task automatic poll(input int b, input logic e);
    for (int k = 0; k < 4000; k++) begin
      rd(SEC_OFS_CTRL);
      if (v[b] === e) break;
    end
  endtask : poll
  // One command, then wait for the start bit to fall
  task automatic run(input logic [2:0] c, input logic [1:0] r, input logic [7:0] h);
    wr(SEC_OFS_CTRL, {16'h0000, h, r, 1'b1, 1'b0, c, 1'b1});
    poll(SEC_B_START, 1'b0);
    chk(v[SEC_B_START], 1'b0);
  endtask : run
  task automatic pulse;
    fr_n <= 1'b0;
    repeat (4) @(posedge mclk);
    fr_n <= 1'b1;
  endtask : pulse
  task automatic t_reset;
    rd(SEC_OFS_CTRL);
    chk(v, 32'h0000_0060);
    rd(SEC_OFS_ADDAT);
    chk(v, 32'h0000_0000);
    rd(8'hC0);
    chk(rs, 2'h2);
    wr(8'hC0, 32'hFFFF_FFFF);
    chk(rs, 2'h2);
    pulse;
    repeat (300) @(posedge mclk);
    chk(spi.cs_n, 1'b1);
    rd(SEC_OFS_CTRL);
    chk(v[SEC_B_ALST], 1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_data;
    wr(SEC_OFS_ADDAT, 32'hC3A5_0007);
    rd(SEC_OFS_ADDAT);
    chk(v, 32'hC3A5_0007);
    run(SEC_CMD_WREN, 2'h1, 8'h00);
    chk(v[SEC_B_WEL], 1'b1);
    run(SEC_CMD_WRITE, 2'h1, 8'h00);
    run(SEC_CMD_RDSR, 2'h1, 8'h00);
    chk(v[SEC_B_WIP], 1'b1);
    run(SEC_CMD_RDSR, 2'h1, 8'h00);
    chk(v[SEC_B_WIP], 1'b0);
    wr(SEC_OFS_ADDAT, 32'h0000_0007);
    run(SEC_CMD_READ, 2'h1, 8'h00);
    rd(SEC_OFS_ADDAT);
    chk(v, 32'hC3A5_0007);
    run(SEC_CMD_WRDI, 2'h3, 8'h00);
    chk(v[15:0], 16'h00E8);
    $display("test data done");
  endtask : t_data
  task automatic t_status;
    run(SEC_CMD_WRSR, 2'h1, 8'hFC);
    chk(v[15:8], 8'h8C);
    run(SEC_CMD_RDSR, 2'h1, 8'h00);
    chk(v[15:8], 8'h8C);
    $display("test status done");
  endtask : t_status
  task automatic t_irq;
    rd(SEC_OFS_ISTAT);
    wr(SEC_OFS_IMASK, 32'h0000_0001);
    run(SEC_CMD_WREN, 2'h3, 8'h00);
    chk(irq, 1'b1);
    rd(SEC_OFS_ISTAT);
    chk(v, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b0);
    wr(SEC_OFS_IMASK, 32'h0000_0000);
    run(SEC_CMD_WRDI, 2'h3, 8'h00);
    chk(irq, 1'b0);
    rd(SEC_OFS_ISTAT);
    chk(v, 32'h0000_0001);
    $display("test irq done");
  endtask : t_irq
  task automatic t_auto;
    wr(SEC_OFS_CTRL, 32'h0000_0040);
    pulse;
    poll(SEC_B_ALST, 1'b1);
    chk(v[SEC_B_ALST], 1'b1);
    rd(SEC_OFS_CFG);
    chk(v, 32'h0000_3210);
    rd(SEC_OFS_ISTAT);
    chk(v, 32'h0000_0002);
    $display("test autoload done");
  endtask : t_auto
  task automatic results;
    $display("errors=%0d tests=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // Watchdog: about 90000 cycles
  initial begin
    #450000;
    num_errors++;
    results;
  end
  initial begin
    num_errors = 0;
    n_tests = 0;
    rstn = 1'b0;
    fr_n = 1'b1;
    req = '0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    t_reset;
    t_data;
    t_status;
    t_irq;
    t_auto;
    results;
  end
endmodule : tb_sec_ctrl
